// ==== verilog/ccb_bridge.sv ====
// Bridge configuration, status, bus watchdog and address remap logic
`timescale 1ns/1ps
`default_nettype none
module ccb_bridge #(
  parameter int WD_SLOW_CYC = ccb_pkg::CCB_WD_SLOW_CYC // Slow timeout
) (
  input  wire logic                clk_in,        // 50 MHz clock
  input  wire logic                rst_in,        // Async reset, high
  input  wire ccb_pkg::ccb_access_t loc_in,       // Local register access
  output logic [7:0]               rdata_out,     // Read data, next cycle
  input  wire ccb_pkg::ccb_access_t rem_in,       // Access from channel
  output logic                     rem_rej_out,   // Remote write dropped
  input  wire logic                seq_err_in,    // Sequence error pulse
  input  wire logic                rx_lock_in,    // Receive lock level
  input  wire logic [6:0]          ser_addr_in,   // Reported address
  input  wire logic                ser_addr_vld_in, // Report strobe
  input  wire ccb_pkg::ccb_fwd_t   txn_in,        // Local bus header
  output ccb_pkg::ccb_fwd_t        fwd_out,       // Forwarded header
  input  wire logic                scl_in,        // SCL pin level
  input  wire logic                sda_in,        // SDA pin level
  output logic                     scl_oe_out,    // Pull SCL low
  output logic                     bus_free_out,  // Bus judged free
  output logic [8:0]               sda_dly_ns_out, // SDA delay setting
  output logic                     irq_out        // Interrupt level
);
  import ccb_pkg::*;

  logic [7:0] ctrl2;
  logic [7:0] farser;
  logic [6:0] farper [2];
  logic [6:0] alias_a [2];
  logic       pass_en;
  logic [3:0] irq_st;
  logic [3:0] irq_msk;
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       scl_q;
  logic       sda_q;
  logic [31:0] wd_cnt;
  ccb_wd_state_t wd_st;
  logic [3:0] pulse_cnt;
  logic [7:0] half_cnt;
  logic       hung_ev;
  logic       free_ev;

  // Accept a write when it names the register; remote ones may be gated
  function automatic logic hit(input ccb_access_t a, input logic [3:0] r);
    hit = a.wr && (a.addr == r);
  endfunction

  wire rem_block = ctrl2[CCB_LWB_BIT];
  wire rem_ok    = rem_in.wr && !rem_block;
  wire rej_ev    = rem_in.wr && rem_block;
  wire [3:0] waddr = loc_in.wr ? loc_in.addr : rem_in.addr;
  wire [7:0] wdata = loc_in.wr ? loc_in.data : rem_in.data;
  wire       wen   = loc_in.wr || rem_ok;
  wire w_ctrl2  = wen && (waddr == CCB_REG_CTRL2);
  wire w_farser = wen && (waddr == CCB_REG_FARSER);
  wire w_misc   = wen && (waddr == CCB_REG_MISC);
  wire w_ist    = hit(loc_in, CCB_REG_IRQ_ST);
  wire w_imsk   = hit(loc_in, CCB_REG_IRQ_MSK);
  wire seq_clr  = w_ctrl2 && wdata[CCB_SEQ_CLR_BIT];
  wire hold     = farser[CCB_HOLD_BIT];
  wire autoload = rx_lock_in && ser_addr_vld_in && !hold && !w_farser;
  wire [31:0] wd_limit = ctrl2[CCB_FAST_BIT] ?
                         32'(CCB_WD_FAST_CYC - 1) : 32'(WD_SLOW_CYC - 1);
  wire wd_dis   = ctrl2[CCB_WD_DIS_BIT];
  wire edge_act = (scl_q != scl_s[1]) || (sda_q != sda_s[1]);

  // Control register; sequence error set wins over a same-cycle clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl2 <= CCB_RESET_VAL;
    end else begin
      if (w_ctrl2) begin
        ctrl2[4:0] <= wdata[4:0];
      end
      ctrl2[CCB_RESERVED_BIT] <= 1'b0;
      ctrl2[CCB_SEQ_CLR_BIT]  <= 1'b0;               // Self-clearing
      if (seq_err_in) begin
        ctrl2[CCB_SEQ_ERR_BIT] <= 1'b1;
      end else if (seq_clr) begin
        ctrl2[CCB_SEQ_ERR_BIT] <= 1'b0;
      end
    end
  end

  // Serializer address: software write, else auto-load unless held
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      farser <= CCB_RESET_VAL;
    end else if (w_farser) begin
      farser <= wdata;
    end else if (autoload) begin
      farser[7:1] <= ser_addr_in;
    end
  end

  // Remap table, one physical and one alias address per entry
  for (genvar i = 0; i < 2; i++) begin : g_map
    wire w_per = wen && (waddr == CCB_REG_FARPER0 + 4'(i));
    wire w_ali = wen && (waddr == CCB_REG_ALIAS0 + 4'(i));
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        farper[i]  <= CCB_ADDR_OFF;
        alias_a[i] <= CCB_ADDR_OFF;
      end else begin
        if (w_per) begin
          farper[i] <= wdata[7:1];
        end
        if (w_ali) begin
          alias_a[i] <= wdata[7:1];
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pass_en <= 1'b0;
    end else if (w_misc) begin
      pass_en <= wdata[CCB_PASS_BIT];
    end
  end

  // Address match; a zero alias or zero serializer address never matches
  wire m0 = (alias_a[0] != CCB_ADDR_OFF) && (txn_in.addr == alias_a[0]);
  wire m1 = (alias_a[1] != CCB_ADDR_OFF) && (txn_in.addr == alias_a[1]);
  wire ms = (farser[7:1] != CCB_ADDR_OFF) && (txn_in.addr == farser[7:1]);
  wire [6:0] fwd_addr = m0 ? farper[0] : (m1 ? farper[1] : txn_in.addr);
  // Local write block plays no part here: target access stays open
  wire fwd_go = txn_in.valid && pass_en && (m0 || m1 || ms);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fwd_out <= '0;
    end else begin
      fwd_out.valid <= fwd_go;
      fwd_out.addr  <= fwd_addr;
    end
  end

  // Pin synchronisers; the second stage and a third-stage copy (scl_q, sda_q) are looked at
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end

  // Watchdog: count idle time, then judge free or drive recovery clocks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wd_st        <= CCB_WD_IDLE;
      wd_cnt       <= '0;
      pulse_cnt    <= '0;
      half_cnt     <= '0;
      scl_oe_out   <= 1'b0;
      bus_free_out <= 1'b0;
      hung_ev      <= 1'b0;
      free_ev      <= 1'b0;
    end else begin
      hung_ev <= 1'b0;
      free_ev <= 1'b0;
      unique case (wd_st)
        CCB_WD_IDLE: begin
          scl_oe_out <= 1'b0;
          if (wd_dis || edge_act) begin
            wd_cnt       <= '0;
            bus_free_out <= 1'b0;
          end else if (wd_cnt >= wd_limit) begin
            wd_cnt <= '0;
            if (sda_q) begin
              bus_free_out <= 1'b1;
              free_ev      <= !bus_free_out;
            end else begin
              wd_st     <= CCB_WD_LOW;
              pulse_cnt <= '0;
              half_cnt  <= '0;
              hung_ev   <= 1'b1;
            end
          end else begin
            wd_cnt <= wd_cnt + 32'h1;
          end
        end
        CCB_WD_LOW, CCB_WD_HIGH: begin
          // Open-drain SCL: pull low for half a period, release for half
          scl_oe_out <= (wd_st == CCB_WD_LOW);
          if (half_cnt == 8'(CCB_SCL_HALF_CYC - 1)) begin
            half_cnt <= '0;
            if (wd_st == CCB_WD_LOW) begin
              wd_st <= CCB_WD_HIGH;
            end else if (pulse_cnt == CCB_PULSES - 4'h1) begin
              wd_st <= CCB_WD_IDLE;
            end else begin
              pulse_cnt <= pulse_cnt + 4'h1;
              wd_st     <= CCB_WD_LOW;
            end
          end else begin
            half_cnt <= half_cnt + 8'h1;
          end
        end
        default: wd_st <= CCB_WD_IDLE;
      endcase
    end
  end

  // SDA delay in ns, base plus one step per code
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_dly_ns_out <= 9'(CCB_DLY_BASE_NS);
    end else begin
      sda_dly_ns_out <= 9'(CCB_DLY_BASE_NS) +
        9'(CCB_DLY_STEP_NS) * {7'h00, ctrl2[CCB_DLY_LO +: 2]};
    end
  end

  // Interrupt status: events set, write one clears; set wins
  wire [3:0] ev = {rej_ev, hung_ev, free_ev, seq_err_in};
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_st      <= '0;
      irq_msk     <= '0;
      irq_out     <= 1'b0;
      rem_rej_out <= 1'b0;
    end else begin
      irq_st      <= ev | (irq_st & ~(w_ist ? loc_in.data[3:0] : 4'h0));
      irq_msk     <= w_imsk ? loc_in.data[3:0] : irq_msk;
      irq_out     <= |(irq_st & irq_msk);
      rem_rej_out <= rej_ev;
    end
  end

  // Read mux; unmapped addresses read zero
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    unique case (loc_in.addr)
      CCB_REG_CTRL2:   rmux = ctrl2;
      CCB_REG_FARSER:  rmux = farser;
      CCB_REG_FARPER0: rmux = {farper[0], 1'b0};
      CCB_REG_FARPER1: rmux = {farper[1], 1'b0};
      CCB_REG_ALIAS0:  rmux = {alias_a[0], 1'b0};
      CCB_REG_ALIAS1:  rmux = {alias_a[1], 1'b0};
      CCB_REG_MISC:    rmux = {7'h00, pass_en};
      CCB_REG_IRQ_ST:  rmux = {4'h0, irq_st};
      CCB_REG_IRQ_MSK: rmux = {4'h0, irq_msk};
      default:         rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= loc_in.rd ? rmux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/ccb_pkg.sv ====
// Package: constants, register map and carrier types of the bridge config
// How it works
// - A forward-channel sequence error sets read-only bit 7 of bridge_control_two.
// - Writing a one to bit 6 of bridge_control_two clears the sequence error flag.
// - Bits 4-3 select SDA output delay 250, 300, 350 or 400 ns in 50 ns steps.
// - With bit 2 set, register writes arriving over the control channel are dropped.
// - Bit 2 does not block remote access to I2C targets on the local bus.
// - Bus watchdog timeout is about 50 us with bit 1 set and about 1 s otherwise.
// - Bit 0 of bridge_control_two disables the bus watchdog.
// - SDA high and idle for the timeout means the bus is treated as free.
// - SDA low and idle for the timeout makes the device drive 9 SCL pulses.
// - Bits 7-1 of far_serializer_address hold the serializer address; 0 disables access.
// - After receive lock the serializer address loads from the serializer report.
// - While the hold bit is set, auto-loading stops and the written value stays.
// - A transaction to an alias address is forwarded with the entry's physical address.
// - Forwarding on an address match happens only while pass-through is enabled.
package ccb_pkg;
  localparam logic [3:0] CCB_REG_CTRL2   = 4'h6;
  localparam logic [3:0] CCB_REG_FARSER  = 4'h7;
  localparam logic [3:0] CCB_REG_FARPER0 = 4'h8;
  localparam logic [3:0] CCB_REG_FARPER1 = 4'h9;
  localparam logic [3:0] CCB_REG_ALIAS0  = 4'ha;
  localparam logic [3:0] CCB_REG_ALIAS1  = 4'hb;
  localparam logic [3:0] CCB_REG_MISC    = 4'hc;
  localparam logic [3:0] CCB_REG_IRQ_ST  = 4'hd;
  localparam logic [3:0] CCB_REG_IRQ_MSK = 4'he;
  localparam int CCB_SEQ_ERR_BIT  = 7;
  localparam int CCB_SEQ_CLR_BIT  = 6;
  localparam int CCB_DLY_LO       = 3;
  localparam int CCB_LWB_BIT      = 2;
  localparam int CCB_FAST_BIT     = 1;
  localparam int CCB_WD_DIS_BIT   = 0;
  localparam int CCB_HOLD_BIT     = 0;
  localparam int CCB_PASS_BIT     = 0;
  localparam int CCB_RESERVED_BIT = 5;
  localparam int CCB_IRQ_SEQ      = 0;
  localparam int CCB_IRQ_FREE     = 1;
  localparam int CCB_IRQ_HUNG     = 2;
  localparam int CCB_IRQ_REJ      = 3;
  localparam logic [7:0] CCB_RESET_VAL = 8'h00;
  localparam logic [6:0] CCB_ADDR_OFF  = 7'h00;
  localparam int CCB_CLK_MHZ        = 50;
  localparam int CCB_DLY_BASE_NS    = 250;
  localparam int CCB_DLY_STEP_NS    = 50;
  localparam int CCB_CLK_NS         = 1000 / CCB_CLK_MHZ;
  localparam int CCB_WD_FAST_US     = 50;
  localparam int CCB_WD_SLOW_S      = 1;
  localparam int CCB_WD_FAST_CYC    = CCB_WD_FAST_US * CCB_CLK_MHZ;
  localparam int CCB_WD_SLOW_CYC    = CCB_WD_SLOW_S * CCB_CLK_MHZ * 1000000;
  localparam int CCB_SCL_HALF_CYC   = 250;
  localparam logic [3:0] CCB_PULSES = 4'h9;

  typedef enum logic [1:0] {
    CCB_WD_IDLE = 2'b00,
    CCB_WD_LOW  = 2'b01,
    CCB_WD_HIGH = 2'b10
  } ccb_wd_state_t;

  // One register access from the local port or the control channel
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] data;
  } ccb_access_t;

  // Transaction header heading for the serializer
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } ccb_fwd_t;
endpackage

// ==== testbench/ccb_checker.sv ====
// Checker: port relations of the bridge configuration block
`timescale 1ns/1ps
`default_nettype none
module ccb_checker (
  input wire logic                 clk_in,        // Clock
  input wire logic                 rst_in,        // Reset
  input wire ccb_pkg::ccb_access_t loc_in,        // Local access
  input wire ccb_pkg::ccb_access_t rem_in,        // Channel access
  input wire logic                 rem_rej_out,   // Refusal
  input wire ccb_pkg::ccb_fwd_t    txn_in,        // Local header
  input wire ccb_pkg::ccb_fwd_t    fwd_out,       // Sent header
  input wire logic                 sda_in,        // SDA level
  input wire logic                 scl_oe_out,    // SCL pull
  input wire logic                 bus_free_out,  // Bus free
  input wire logic [8:0]           sda_dly_ns_out // Delay
);
  import ccb_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Register, then delay stage: the new setting is seen two edges later
  property p_dly;
    logic [1:0] d;
    (loc_in.wr && loc_in.addr == CCB_REG_CTRL2, d = loc_in.data[4:3])
      |-> ##2 sda_dly_ns_out == 9'(CCB_DLY_BASE_NS) +
              9'(CCB_DLY_STEP_NS) * {7'h00, d};
  endproperty
  a_dly: assert property (p_dly) else $error("bad sda delay");
  property p_fwd;
    fwd_out.valid |-> $past(txn_in.valid);
  endproperty
  a_fwd: assert property (p_fwd) else $error("stray forward");
  property p_rej;
    rem_rej_out |-> $past(rem_in.wr);
  endproperty
  a_rej: assert property (p_rej) else $error("stray refusal");
  // A free verdict needs SDA high well before it
  property p_free;
    $rose(bus_free_out) |-> $past(sda_in, 8) && $past(sda_in, 16);
  endproperty
  a_free: assert property (p_free) else $error("free with SDA low");
  property p_excl;
    !(scl_oe_out && bus_free_out);
  endproperty
  a_excl: assert property (p_excl) else $error("free while pulsing");
  property p_hung;
    $rose(scl_oe_out) |-> !$past(sda_in, 8);
  endproperty
  a_hung: assert property (p_hung) else $error("pulse, SDA high");
  // Recovery pulses are long; eight cycles is enough to catch a glitch
  property p_pulse;
    $rose(scl_oe_out) |=> scl_oe_out [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("short low");
  property p_gap;
    $fell(scl_oe_out) |=> !scl_oe_out [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("short release");
endmodule
bind ccb_bridge ccb_checker chk_i (.clk_in(clk_in), .rst_in(rst_in),
  .loc_in(loc_in), .rem_in(rem_in), .rem_rej_out(rem_rej_out),
  .txn_in(txn_in), .fwd_out(fwd_out), .sda_in(sda_in),
  .scl_oe_out(scl_oe_out), .bus_free_out(bus_free_out),
  .sda_dly_ns_out(sda_dly_ns_out));
`default_nettype wire

// ==== testbench/ccb_far_model.sv ====
// Partner model: serializer address reports and local I2C lines
`timescale 1ns/1ps
`default_nettype none
module ccb_far_model (
  input  wire logic       clk_in,     // Clock
  input  wire logic       scl_oe_in,  // Device pulls SCL
  output var  logic       scl_out,    // SCL level
  output var  logic       sda_out,    // SDA level
  output var  logic       rx_lock_out, // Receive lock
  output var  logic [6:0] ser_addr_out, // Reported address
  output var  logic       ser_addr_vld_out // Report strobe
);
  logic sda_low = 1'b0; // Stuck target holds SDA
  // Pull-ups: a released line reads high
  assign scl_out = ~scl_oe_in;
  assign sda_out = ~sda_low;
  initial begin
    rx_lock_out = 1'b0;
    ser_addr_out = 7'h00;
    ser_addr_vld_out = 1'b0;
  end
  // Lock, then one address report; stale address is inverted after
  task automatic report(input logic [6:0] a);
    rx_lock_out <= 1'b1;
    ser_addr_out <= a;
    ser_addr_vld_out <= 1'b1;
    @(posedge clk_in);
    ser_addr_out <= ~a;
    ser_addr_vld_out <= 1'b0;
    @(posedge clk_in);
  endtask
  // Short SDA dip counts as bus activity
  task automatic wiggle();
    sda_low <= 1'b1;
    repeat (2) @(posedge clk_in);
    sda_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Testbench: registers, status, remap and bus watchdog
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccb_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, seq = 1'b0, p;
  ccb_access_t loc = '0, rem = '0;
  ccb_fwd_t    txn = '0, fwd;
  logic [7:0]  rdata;
  logic [8:0]  dly;
  logic [6:0]  sadr;
  logic        scl, sda, lock, svld, rej, oe, free, irq;
  int          err_count = 0, total_checks = 0, n, c;
  always #10 clk_in = ~clk_in;
  ccb_bridge #(.WD_SLOW_CYC(5000)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .loc_in(loc), .rdata_out(rdata), .rem_in(rem), .rem_rej_out(rej),
    .seq_err_in(seq), .rx_lock_in(lock), .ser_addr_in(sadr),
    .ser_addr_vld_in(svld), .txn_in(txn), .fwd_out(fwd), .scl_in(scl),
    .sda_in(sda), .scl_oe_out(oe), .bus_free_out(free),
    .sda_dly_ns_out(dly), .irq_out(irq));
  ccb_far_model far (.clk_in(clk_in), .scl_oe_in(oe), .scl_out(scl),
    .sda_out(sda), .rx_lock_out(lock), .ser_addr_out(sadr),
    .ser_addr_vld_out(svld));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus tasks start and end on a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    loc <= {2'b10, a, d};
    @(posedge clk_in);
    loc <= '0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    loc <= {2'b01, a, 8'h00};
    @(posedge clk_in);
    loc <= '0;
    #1 chk({1'b0, rdata}, {1'b0, e});
    @(posedge clk_in);
  endtask
  task automatic rw(input logic [3:0] a, input logic [7:0] d, input logic e);
    rem <= {2'b10, a, d};
    @(posedge clk_in);
    rem <= '0;
    #1 chk(9'(rej), 9'(e));
    @(posedge clk_in);
  endtask
  task automatic fw(input logic [6:0] a, input logic [7:0] e);
    txn <= {1'b1, a};
    @(posedge clk_in);
    txn <= '0;
    #1 chk({1'b0, fwd}, {1'b0, e});
    @(posedge clk_in);
  endtask
  // Settle time lets the edge clear a stale free verdict first
  task automatic wait_free(output int k);
    far.wiggle();
    repeat (8) @(negedge clk_in);
    for (k = 8; k < 6000 && free !== 1'b1; k++) @(negedge clk_in);
    @(posedge clk_in);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_in);
    err_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int i = 6; i < 10; i++) rd(4'(i), 8'h00);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(CCB_REG_CTRL2, 8'h40 | 8'(i << 3));
      #1 chk(dly, 9'(CCB_DLY_BASE_NS + CCB_DLY_STEP_NS * i));
      @(posedge clk_in);
      rd(CCB_REG_CTRL2, 8'(i << 3));
    end
    // Sequence error stays until cleared
    wr(CCB_REG_IRQ_MSK, 8'h0f);
    seq <= 1'b1;
    @(posedge clk_in);
    seq <= 1'b0;
    repeat (20) @(posedge clk_in);
    rd(CCB_REG_CTRL2, 8'h98);
    #1 chk(9'(irq), 9'h001);
    @(posedge clk_in);
    rd(CCB_REG_IRQ_ST, 8'h01);
    wr(CCB_REG_CTRL2, 8'h40);
    rd(CCB_REG_CTRL2, 8'h00);
    wr(CCB_REG_IRQ_ST, 8'h01);
    #1 chk(9'(irq), 9'h000);
    @(posedge clk_in);
    // Remote write blocking and address remap
    wr(CCB_REG_ALIAS0, 8'ha0);
    wr(CCB_REG_FARPER0, 8'h22);
    wr(CCB_REG_CTRL2, 8'h04);
    rw(CCB_REG_FARPER0, 8'h66, 1'b1);
    rd(CCB_REG_FARPER0, 8'h22);
    rd(CCB_REG_IRQ_ST, 8'h08);
    fw(7'h50, 8'h11);
    wr(CCB_REG_MISC, 8'h01);
    fw(7'h50, 8'h91);
    wr(CCB_REG_CTRL2, 8'h00);
    rw(CCB_REG_FARPER0, 8'h66, 1'b0);
    fw(7'h50, 8'hb3);
    fw(7'h00, 8'h00);
    // Second remap entry, then serializer address load and hold
    wr(CCB_REG_ALIAS1, 8'h62);
    wr(CCB_REG_FARPER1, 8'h0e);
    rd(CCB_REG_ALIAS1, 8'h62);
    fw(7'h31, 8'h87);
    far.report(7'h2a);
    rd(CCB_REG_FARSER, 8'h54);
    wr(CCB_REG_FARSER, 8'h37);
    far.report(7'h15);
    rd(CCB_REG_FARSER, 8'h37);
    fw(7'h1b, 8'h9b);
    // Watchdog: fast, slow, disabled, then a hung bus
    wr(CCB_REG_CTRL2, 8'h02);
    wait_free(n);
    chk(9'(n > CCB_WD_FAST_CYC - 10 && n < CCB_WD_FAST_CYC + 30), 9'h001);
    wr(CCB_REG_CTRL2, 8'h00);
    wait_free(n);
    chk(9'(n > 4990 && n < 5030), 9'h001);
    wr(CCB_REG_CTRL2, 8'h01);
    wait_free(n);
    chk(9'(free), 9'h000);
    wr(CCB_REG_CTRL2, 8'h02);
    far.sda_low <= 1'b1;
    for (n = 0; n < 3000 && oe !== 1'b1; n++) @(negedge clk_in);
    c = 0;
    p = 1'b0;
    for (n = 0; n < 5000; n++) begin
      if (oe && !p) c++;
      p = oe;
      @(negedge clk_in);
    end
    chk(9'(c), 9'd9);
    @(posedge clk_in);
    rd(CCB_REG_IRQ_ST, 8'h0e);
    #1 chk(9'(irq), 9'h001);
    @(posedge clk_in);
    far.sda_low <= 1'b0;
    test_done();
  end
endmodule
`default_nettype wire
